// File: gpio_port_keyboard_interrupt_tb.sv
// Self-checking bench of the GPIO and keypad block
`timescale 1ns/1ps
module gpio_port_keyboard_interrupt_tb;
    logic        aclk, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, own = 32'h0, key_en = 32'h0, key_val = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq1, irq2, wake_req;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, pad_in, pad_out, pad_oe, pad_pu, pad_pd, pad_slew, rd_v;
    int          err_count = 0, n_compared = 0;
    localparam logic [31:0] MD = 32'hff00_0000;
    gpk_top i_gpk_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_slew(pad_slew), .periph_own(own),
        .periph_out(own), .periph_oe(own), .irq_keypad_unit_one(irq1),
        .irq_keypad_unit_two(irq2), .wake_req(wake_req));
    gpk_keys i_gpk_keys (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pu(pad_pu),
        .pad_pd(pad_pd), .key_en(key_en), .key_val(key_val), .pad_in(pad_in));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic end_sim;
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tmo;
        err_count++;
        $display("unexpected timeout at %0t", $time);
        end_sim();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 20) tmo();
        rsp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        int n;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 20) tmo();
        rd_v = rdata;
        rsp  = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Waits a few cycles for an interrupt level, then judges it
    task automatic wirq(input logic u, input logic v);
        int n;
        for (n = 0; n < 10 && (u ? irq2 : irq1) !== v; n++) @(posedge aclk);
        chk(32'(u ? irq2 : irq1), 32'(v));
    endtask
    task automatic t_reset;
        chk(pad_oe, 32'h0000_0004);
        rd(8'h04);
        chk(rd_v, 32'h0);
        rd(8'h80);
        chk(32'(rsp), 32'(gpk_pkg::GPK_RESP_SLVERR));
        wr(8'h80, 32'h0);
        chk(32'(rsp), 32'(gpk_pkg::GPK_RESP_SLVERR));
        chk(32'(wake_req), 32'h0);
    endtask
    task automatic t_gpio;
        wr(8'h34, 32'hff);
        wr(8'h30, 32'ha5);
        wr(8'h3c, 32'h0f);
        wr(8'h38, 32'hff);
        chk(32'(rsp), 32'(gpk_pkg::GPK_RESP_OKAY));
        cyc(2);
        chk(pad_out & MD, 32'ha500_0000);
        chk(pad_oe & MD, MD);
        chk(pad_slew & MD, 32'h0f00_0000);
        chk(pad_pu & MD, 32'h0);
        rd(8'h30);
        chk(rd_v, 32'ha5);
        wr(8'h34, 32'h0);
        cyc(2);
        chk(pad_pu & MD, MD);
        rd(8'h30);
        chk(rd_v, 32'hff);
        own <= 32'h0100_0000;
        cyc(2);
        chk(pad_oe & MD, 32'h0100_0000);
        chk(pad_pu & MD, 32'hfe00_0000);
        own <= 32'h0;
        cyc(2);
        chk(pad_oe | pad_pu & MD, 32'hff00_0004);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h04);
        cyc(2);
        chk(pad_oe & pad_out & 32'h4, 32'h4);
        rd(8'h00);
        chk(rd_v & 32'h4, 32'h0);
    endtask
    task automatic t_kb1;
        key_en  <= 32'h100;
        key_val <= 32'h100;
        wr(8'h40, 32'h1);
        wr(8'h44, 32'h1);
        wr(8'h40, 32'h9);
        cyc(2);
        chk(pad_pu & 32'h100 | pad_pd & 32'h100, 32'h100);
        chk(32'(irq1), 32'h0);
        key_val <= 32'h0;
        wirq(1'b0, 1'b1);
        chk(32'(wake_req), 32'h1);
        rd(8'h40);
        chk(rd_v & 32'h10, 32'h10);
        wr(8'h40, 32'h9);
        wirq(1'b0, 1'b0);
        wr(8'h40, 32'hb);
        cyc(3);
        chk(32'(irq1), 32'h1);
        key_val <= 32'h100;
        wr(8'h40, 32'hb);
        wirq(1'b0, 1'b0);
        wr(8'h40, 32'h0);
        key_val <= 32'h0;
        cyc(4);
        chk(32'(irq1), 32'h0);
        rd(8'h40);
        chk(rd_v & 32'h10, 32'h10);
    endtask
    task automatic t_kb2;
        key_en  <= 32'h3_0000;
        key_val <= 32'h0;
        wr(8'h48, 32'h5);
        wr(8'h4c, 32'h2);
        wr(8'h48, 32'hd);
        cyc(2);
        chk(pad_pd & 32'h3_0000 | pad_pu & 32'h2_0000, 32'h2_0000);
        key_val <= 32'h1_0000;
        cyc(4);
        chk(32'(irq2), 32'h0);
        key_val <= 32'h3_0000;
        wirq(1'b1, 1'b1);
        key_val <= 32'h0;
        wr(8'h48, 32'hd);
        wirq(1'b1, 1'b0);
        own <= 32'h2_0000;
        cyc(4);
        chk(32'(irq2), 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(2);
        t_reset();
        t_gpio();
        t_kb1();
        t_kb2();
        end_sim();
    end
endmodule // gpio_port_keyboard_interrupt_tb

// File: gpk_defs.svh
// Register offsets, field positions and reset values of the GPIO and keypad block
`ifndef GPK_DEFS_SVH
`define GPK_DEFS_SVH
`define GPK_ADDR_W      8
`define GPK_PORT_STRIDE 8'h10
`define GPK_OFF_DATA    2'h0
`define GPK_OFF_DIR     2'h1
`define GPK_OFF_PULL    2'h2
`define GPK_OFF_SLEW    2'h3
`define GPK_KU1_CTRL    8'h40
`define GPK_KU1_EN      8'h44
`define GPK_KU2_CTRL    8'h48
`define GPK_KU2_EN      8'h4c
`define GPK_CTL_IE      0
`define GPK_CTL_MODE    1
`define GPK_CTL_POL     2
`define GPK_CTL_ACK     3
`define GPK_CTL_PEND    4
`define GPK_RST_BYTE    8'h00
`define GPK_RST_WORD    32'h0000_0000
`define GPK_OUT_ONLY    2
`define GPK_KU1_LSB     8
`define GPK_KU2_LSB     16
`endif

// File: gpk_keypad_unit.sv
// One keypad interrupt unit: edge latch, level hold, mask and wake path
`timescale 1ns/1ps
module gpk_keypad_unit #(
    parameter int N = 8
) (
    input  logic                aclk,
    input  logic                aresetn,
    input  logic [N-1:0]        pins,
    input  logic [N-1:0]        en,
    input  gpk_pkg::gpk_sense_t mode,
    input  gpk_pkg::gpk_pol_t   pol,
    input  logic                ie,
    input  logic                ack,
    output logic                pending,
    output logic                irq,
    output logic                wake
);
    wire          rise    = (pol == gpk_pkg::GPK_POL_RISE_HIGH);
    wire [N-1:0]  active  = (rise ? pins : ~pins) & en;                  // R09 R11
    logic [N-1:0] prev;
    wire          edge_hit = |(active & ~prev);                           // R10
    wire          lvl_hit  = (mode == gpk_pkg::GPK_SENSE_EDGE_LEVEL) & (|active); // R10
    wire          next_pending = edge_hit | (pending & ~ack);            // R16
    // No clock in this path, so it still works with clocks stopped
    assign wake = |active;                                               // R14

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev    <= '0;
            pending <= 1'b0;
            irq     <= 1'b0;
        end else begin
            prev    <= active;
            pending <= next_pending;
            irq     <= ie & (next_pending | lvl_hit);                    // R13 R16
        end
    end

    property p_edge_sets;
        @(posedge aclk) disable iff (!aresetn) edge_hit |=> pending;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge lost"); // R16
    property p_pend_holds;
        @(posedge aclk) disable iff (!aresetn) pending && !ack |=> pending;
    endproperty
    a_pend_holds: assert property (p_pend_holds) else $error("pending dropped"); // R16
    property p_mask;
        @(posedge aclk) disable iff (!aresetn) !ie |=> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq while masked"); // R13
    property p_irq_on_pend;
        @(posedge aclk) disable iff (!aresetn) ie && edge_hit |=> irq && pending;
    endproperty
    a_irq_on_pend: assert property (p_irq_on_pend) else $error("irq missing"); // R13
    property p_level_holds;
        @(posedge aclk) disable iff (!aresetn) ie && lvl_hit |=> irq;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level irq lost"); // R10
    property p_disabled;
        @(posedge aclk) disable iff (!aresetn) (en == '0) && (!pending || ack) |=> !pending;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled pin set pending"); // R09
    c_level: cover property (@(posedge aclk) disable iff (!aresetn) ack && lvl_hit ##1 irq);
endmodule // gpk_keypad_unit

// File: gpk_keys.sv
// Behavioural model of keys and circuitry on the pads
`timescale 1ns/1ps
module gpk_keys (
    input  logic        aclk,
    input  logic [31:0] pad_out,
    input  logic [31:0] pad_oe,
    input  logic [31:0] pad_pu,
    input  logic [31:0] pad_pd,
    input  logic [31:0] key_en,
    input  logic [31:0] key_val,
    output logic [31:0] pad_in
);
    logic [31:0] flt = 32'h5555_5555;
    // Floating pins wander, so a stale level is never mistaken for a real one
    always @(posedge aclk) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (key_en[i]) pad_in[i] = key_val[i];
            else if (pad_pu[i]) pad_in[i] = 1'b1;
            else if (pad_pd[i]) pad_in[i] = 1'b0;
            else pad_in[i] = flt[i];
        end
    end
endmodule // gpk_keys

// File: gpk_pad_mux.sv
// Per-pin selection of drive, enable and pull resistors
`timescale 1ns/1ps
`include "gpk_defs.svh"
module gpk_pad_mux #(
    parameter int PINS = 32
) (
    input  logic [PINS-1:0] dout,
    input  logic [PINS-1:0] dir,
    input  logic [PINS-1:0] pull_en,
    input  logic [PINS-1:0] own,
    input  logic [PINS-1:0] own_out,
    input  logic [PINS-1:0] own_oe,
    input  logic [PINS-1:0] kb_en,
    input  logic [PINS-1:0] kb_rise,
    output logic [PINS-1:0] out,
    output logic [PINS-1:0] oe,
    output logic [PINS-1:0] pu,
    output logic [PINS-1:0] pd
);
    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            wire gp_oe = (i == `GPK_OUT_ONLY) ? 1'b1 : dir[i];           // R03 R06
            assign out[i] = own[i] ? own_out[i] : dout[i];               // R01 R02
            assign oe[i]  = own[i] ? own_oe[i] : gp_oe;                  // R01
            // Keypad pull follows the sense polarity and overrides the user pull-up
            assign pu[i]  = kb_en[i] ? ~kb_rise[i] : (pull_en[i] & ~oe[i] & ~own[i]); // R04 R12
            assign pd[i]  = kb_en[i] & kb_rise[i];                       // R12
        end
    endgenerate
endmodule // gpk_pad_mux

// File: gpk_pkg.sv
// Types shared by the GPIO and keypad block
package gpk_pkg;
    typedef enum logic {
        GPK_SENSE_EDGE       = 1'b0,
        GPK_SENSE_EDGE_LEVEL = 1'b1
    } gpk_sense_t;
    typedef enum logic {
        GPK_POL_FALL_LOW  = 1'b0,
        GPK_POL_RISE_HIGH = 1'b1
    } gpk_pol_t;
    typedef enum logic [1:0] {
        GPK_RESP_OKAY   = 2'b00,
        GPK_RESP_SLVERR = 2'b10
    } gpk_resp_t;
endpackage

// File: gpk_top.sv
// GPIO ports and two keypad interrupt units behind an AXI4-Lite slave
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gpk_defs.svh"
// Contract
// R01 - Unowned pins return to GPIO control
// R02 - Data read gives pin, write drives
// R03 - Direction bit selects input or output
// R04 - Pull-up only acts on input pins; a live keypad pin set as output still gets its falling/low keypad pull-up
// R05 - Slew bit goes to output buffer
// R06 - Four ports of eight; A2 output only
// R07 - Unit one: eight pins, own enables
// R08 - Unit two: port C low four
// R09 - Only enabled keypad pins request interrupts
// R10 - Edge only or edge plus level
// R11 - Polarity rising/high or falling/low
// R12 - Polarity picks pull-down or pull-up
// R13 - Per-unit enable gates interrupt output
// R14 - Asynchronous keypad wake-up request
// R15 - Port C shared by unit two, SPI
// R16 - Edge latches pending until software acknowledge
module gpk_top #(
    parameter int AW    = `GPK_ADDR_W,
    parameter int PINS  = 32,
    parameter int KU1_N = 8,
    parameter int KU2_N = 4
) (
    input  logic            aclk,
    input  logic            aresetn,
    input  logic [AW-1:0]   s_axi_awaddr,
    input  logic            s_axi_awvalid,
    output logic            s_axi_awready,
    input  logic [31:0]     s_axi_wdata,
    input  logic [3:0]      s_axi_wstrb,
    input  logic            s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  logic            s_axi_bready,
    input  logic [AW-1:0]   s_axi_araddr,
    input  logic            s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  logic            s_axi_rready,
    input  logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pu,
    output logic [PINS-1:0] pad_pd,
    output logic [PINS-1:0] pad_slew,
    input  logic [PINS-1:0] periph_own,
    input  logic [PINS-1:0] periph_out,
    input  logic [PINS-1:0] periph_oe,
    output logic            irq_keypad_unit_one,
    output logic            irq_keypad_unit_two,
    output logic            wake_req
);
    // Software-visible state
    logic [PINS-1:0]     dout;
    logic [PINS-1:0]     dir;
    logic [PINS-1:0]     pull_en;
    logic [PINS-1:0]     slew;
    logic [1:0]          ku_ie;
    gpk_pkg::gpk_sense_t ku1_mode;
    gpk_pkg::gpk_sense_t ku2_mode;
    gpk_pkg::gpk_pol_t   ku1_pol;
    gpk_pkg::gpk_pol_t   ku2_pol;
    logic [KU1_N-1:0]    ku1_en;
    logic [KU2_N-1:0]    ku2_en;

    // Write channel holding registers
    logic                aw_full;
    logic                w_full;
    logic [AW-1:0]       aw_addr;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;

    // Keypad status
    logic                ku1_pending;
    logic                ku2_pending;
    logic                ku1_irq;
    logic                ku2_irq;
    logic                ku1_wake;
    logic                ku2_wake;

    // Write channel: address and data are taken independently, in either order
    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_full & w_full & ~s_axi_bvalid;
    wire next_aw_full = do_write ? 1'b0 : (aw_full | aw_take);
    wire next_w_full  = do_write ? 1'b0 : (w_full | w_take);
    wire next_bvalid  = do_write | (s_axi_bvalid & ~s_axi_bready);

    // Write address decode
    wire       wa_port  = (aw_addr < `GPK_KU1_CTRL) & (aw_addr[1:0] == 2'h0);
    wire [1:0] wa_pidx  = aw_addr[5:4];
    wire [1:0] wa_sel   = aw_addr[3:2];
    wire       wa_k1c   = (aw_addr == `GPK_KU1_CTRL);
    wire       wa_k1e   = (aw_addr == `GPK_KU1_EN);
    wire       wa_k2c   = (aw_addr == `GPK_KU2_CTRL);
    wire       wa_k2e   = (aw_addr == `GPK_KU2_EN);
    wire       wa_hit   = wa_port | wa_k1c | wa_k1e | wa_k2c | wa_k2e;
    wire       wr_en    = do_write & wa_hit & w_strb[0];
    wire [7:0] wr_byte  = w_data[7:0];
    wire [4:0] wr_base  = {wa_pidx, 3'h0};

    // Acknowledge is a write-one pulse; it is not stored
    wire ku1_ack = wr_en & wa_k1c & wr_byte[`GPK_CTL_ACK];               // R16
    wire ku2_ack = wr_en & wa_k2c & wr_byte[`GPK_CTL_ACK];               // R16

    // Read channel
    wire ar_take     = s_axi_arvalid & s_axi_arready;
    wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // Read address decode
    wire       ra_port = (s_axi_araddr < `GPK_KU1_CTRL) & (s_axi_araddr[1:0] == 2'h0);
    wire [1:0] ra_pidx = s_axi_araddr[5:4];
    wire [1:0] ra_sel  = s_axi_araddr[3:2];
    wire [4:0] rd_base = {ra_pidx, 3'h0};
    wire       ra_k1c  = (s_axi_araddr == `GPK_KU1_CTRL);
    wire       ra_k1e  = (s_axi_araddr == `GPK_KU1_EN);
    wire       ra_k2c  = (s_axi_araddr == `GPK_KU2_CTRL);
    wire       ra_k2e  = (s_axi_araddr == `GPK_KU2_EN);
    wire       ra_hit  = ra_port | ra_k1c | ra_k1e | ra_k2c | ra_k2e;

    // The output-only pin has no input path, so it always reads low
    wire [PINS-1:0] pin_view = pad_in & ~(32'h1 << `GPK_OUT_ONLY);       // R02 R06
    wire [7:0] rd_in   = pin_view[rd_base +: 8];
    wire [7:0] rd_dir  = dir[rd_base +: 8];
    wire [7:0] rd_pull = pull_en[rd_base +: 8];
    wire [7:0] rd_slew = slew[rd_base +: 8];
    wire [7:0] rd_pbyte = (ra_sel == `GPK_OFF_DATA) ? rd_in :
                          (ra_sel == `GPK_OFF_DIR)  ? rd_dir :
                          (ra_sel == `GPK_OFF_PULL) ? rd_pull : rd_slew;
    wire [7:0] rd_k1c  = {3'h0, ku1_pending, 1'b0, ku1_pol, ku1_mode, ku_ie[0]};
    wire [7:0] rd_k2c  = {3'h0, ku2_pending, 1'b0, ku2_pol, ku2_mode, ku_ie[1]};
    wire [7:0] rd_k2e  = {{(8-KU2_N){1'b0}}, ku2_en};
    wire [7:0] rd_byte = ra_port ? rd_pbyte :
                         ra_k1c  ? rd_k1c :
                         ra_k1e  ? ku1_en :
                         ra_k2c  ? rd_k2c :
                         ra_k2e  ? rd_k2e : 8'h00;

    // Register bus handshake state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= `GPK_RST_WORD;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= gpk_pkg::GPK_RESP_OKAY;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= ~next_aw_full;
            s_axi_wready  <= ~next_w_full;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= wa_hit ? gpk_pkg::GPK_RESP_OKAY : gpk_pkg::GPK_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `GPK_RST_WORD;
            s_axi_rresp   <= gpk_pkg::GPK_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid  <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= {24'h0, rd_byte};                         // R02
                s_axi_rresp <= ra_hit ? gpk_pkg::GPK_RESP_OKAY : gpk_pkg::GPK_RESP_SLVERR;
            end
        end
    end

    // Port registers: one byte lane per port per register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout    <= `GPK_RST_WORD;
            dir     <= `GPK_RST_WORD;
            pull_en <= `GPK_RST_WORD;
            slew    <= `GPK_RST_WORD;
        end else if (wr_en && wa_port) begin
            case (wa_sel)
                `GPK_OFF_DATA: dout[wr_base +: 8]    <= wr_byte;         // R02
                `GPK_OFF_DIR:  dir[wr_base +: 8]     <= wr_byte;         // R03
                `GPK_OFF_PULL: pull_en[wr_base +: 8] <= wr_byte;         // R04
                `GPK_OFF_SLEW: slew[wr_base +: 8]    <= wr_byte;         // R05
                default:       dout[wr_base +: 8]    <= dout[wr_base +: 8];
            endcase
        end
    end

    // Keypad configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ku_ie    <= 2'h0;
            ku1_mode <= gpk_pkg::GPK_SENSE_EDGE;
            ku2_mode <= gpk_pkg::GPK_SENSE_EDGE;
            ku1_pol  <= gpk_pkg::GPK_POL_FALL_LOW;
            ku2_pol  <= gpk_pkg::GPK_POL_FALL_LOW;
            ku1_en   <= '0;
            ku2_en   <= '0;
        end else if (wr_en) begin
            if (wa_k1c) begin
                ku_ie[0] <= wr_byte[`GPK_CTL_IE];                        // R13
                ku1_mode <= gpk_pkg::gpk_sense_t'(wr_byte[`GPK_CTL_MODE]); // R10
                ku1_pol  <= gpk_pkg::gpk_pol_t'(wr_byte[`GPK_CTL_POL]);  // R11
            end
            if (wa_k2c) begin
                ku_ie[1] <= wr_byte[`GPK_CTL_IE];                        // R13
                ku2_mode <= gpk_pkg::gpk_sense_t'(wr_byte[`GPK_CTL_MODE]); // R10
                ku2_pol  <= gpk_pkg::gpk_pol_t'(wr_byte[`GPK_CTL_POL]);  // R11
            end
            if (wa_k1e) begin
                ku1_en <= wr_byte[KU1_N-1:0];                            // R07
            end
            if (wa_k2e) begin
                ku2_en <= wr_byte[KU2_N-1:0];                            // R08
            end
        end
    end

    // A pin taken by its peripheral (SPI on port C) is not a keypad input
    wire [KU1_N-1:0] ku1_pins = pad_in[`GPK_KU1_LSB +: KU1_N];
    wire [KU2_N-1:0] ku2_pins = pad_in[`GPK_KU2_LSB +: KU2_N];
    wire [KU1_N-1:0] ku1_live = ku1_en & ~periph_own[`GPK_KU1_LSB +: KU1_N]; // R01
    wire [KU2_N-1:0] ku2_live = ku2_en & ~periph_own[`GPK_KU2_LSB +: KU2_N]; // R15
    wire             ku1_rise = (ku1_pol == gpk_pkg::GPK_POL_RISE_HIGH);
    wire             ku2_rise = (ku2_pol == gpk_pkg::GPK_POL_RISE_HIGH);
    wire [PINS-1:0]  kb_en    = {{(PINS-`GPK_KU2_LSB-KU2_N){1'b0}}, ku2_live,
                                 ku1_live, {`GPK_KU1_LSB{1'b0}}};
    wire [PINS-1:0]  kb_rise  = {{(PINS-`GPK_KU2_LSB-KU2_N){1'b0}}, {KU2_N{ku2_rise}},
                                 {KU1_N{ku1_rise}}, {`GPK_KU1_LSB{1'b0}}};

    gpk_keypad_unit #(
        .N       (KU1_N)
    ) u_keypad_unit_one (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (ku1_pins),
        .en      (ku1_live),
        .mode    (ku1_mode),
        .pol     (ku1_pol),
        .ie      (ku_ie[0]),
        .ack     (ku1_ack),
        .pending (ku1_pending),
        .irq     (ku1_irq),
        .wake    (ku1_wake)
    );

    gpk_keypad_unit #(
        .N       (KU2_N)
    ) u_keypad_unit_two (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (ku2_pins),
        .en      (ku2_live),
        .mode    (ku2_mode),
        .pol     (ku2_pol),
        .ie      (ku_ie[1]),
        .ack     (ku2_ack),
        .pending (ku2_pending),
        .irq     (ku2_irq),
        .wake    (ku2_wake)
    );

    // Wake must pass while the clock is stopped, so it is the one unregistered output
    assign wake_req = ku1_wake | ku2_wake;                               // R14

    logic [PINS-1:0] mux_out;
    logic [PINS-1:0] mux_oe;
    logic [PINS-1:0] mux_pu;
    logic [PINS-1:0] mux_pd;

    gpk_pad_mux #(
        .PINS    (PINS)
    ) u_pad_mux (
        .dout    (dout),
        .dir     (dir),
        .pull_en (pull_en),
        .own     (periph_own),
        .own_out (periph_out),
        .own_oe  (periph_oe),
        .kb_en   (kb_en),
        .kb_rise (kb_rise),
        .out     (mux_out),
        .oe      (mux_oe),
        .pu      (mux_pu),
        .pd      (mux_pd)
    );

    // Pad controls are registered: one cycle from register write to pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_out             <= `GPK_RST_WORD;
            pad_oe              <= `GPK_RST_WORD;
            pad_pu              <= `GPK_RST_WORD;
            pad_pd              <= `GPK_RST_WORD;
            pad_slew            <= `GPK_RST_WORD;
            irq_keypad_unit_one <= 1'b0;
            irq_keypad_unit_two <= 1'b0;
        end else begin
            pad_out             <= mux_out;                              // R01 R02
            pad_oe              <= mux_oe;                               // R03 R06
            pad_pu              <= mux_pu;                               // R04 R12
            pad_pd              <= mux_pd;                               // R12
            pad_slew            <= slew;                                 // R05
            irq_keypad_unit_one <= ku1_irq;                              // R13
            irq_keypad_unit_two <= ku2_irq;                              // R13
        end
    end

    property p_out_only;
        @(posedge aclk) disable iff (!aresetn)
            aresetn && !periph_own[`GPK_OUT_ONLY] |=> pad_oe[`GPK_OUT_ONLY];
    endproperty
    a_out_only: assert property (p_out_only) else $error("A2 not driven"); // R06
    property p_owner;
        @(posedge aclk) disable iff (!aresetn)
            aresetn |=> ((pad_out ^ $past(periph_out)) & $past(periph_own)) == '0
                        && ((pad_oe ^ $past(periph_oe)) & $past(periph_own)) == '0;
    endproperty
    a_owner: assert property (p_owner) else $error("peripheral not routed"); // R01
    property p_pull_out;
        @(posedge aclk) disable iff (!aresetn)
            1'b1 |-> (pad_pu & pad_oe & ~$past(kb_en)) == '0;
    endproperty
    a_pull_out: assert property (p_pull_out) else $error("pull-up on output"); // R04
    property p_kb_pull;
        @(posedge aclk) disable iff (!aresetn)
            kb_en[`GPK_KU1_LSB] |=> pad_pd[`GPK_KU1_LSB] == $past(ku1_rise)
                                 && pad_pu[`GPK_KU1_LSB] == !$past(ku1_rise);
    endproperty
    a_kb_pull: assert property (p_kb_pull) else $error("keypad pull wrong"); // R12
    property p_data_read;
        @(posedge aclk) disable iff (!aresetn)
            ar_take && ra_port && ra_sel == `GPK_OFF_DATA
            |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(rd_in);
    endproperty
    a_data_read: assert property (p_data_read) else $error("pin read wrong"); // R02
    property p_bresp_hold;
        @(posedge aclk) disable iff (!aresetn)
            s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn) do_write |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("no write response");
    property p_slew;
        @(posedge aclk) disable iff (!aresetn) 1'b1 |=> pad_slew == $past(slew);
    endproperty
    a_slew: assert property (p_slew) else $error("slew not passed"); // R05

    c_write: cover property (@(posedge aclk) disable iff (!aresetn) do_write ##1 s_axi_bvalid);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) ar_take ##1 s_axi_rvalid);
    c_irq1: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_keypad_unit_one));
    c_irq2: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_keypad_unit_two));
endmodule // gpk_top
